/* verilog/operand_address_generator.sv */
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Multiply takes accumulator and X as factors, writes 16-bit product to acc_pair.
// RULE2 - Word divide reads dividend from acc_pair and writes quotient back there.
// RULE3 - Decimal adjust after add or subtract corrects the accumulator in place.
// RULE4 - Digit rotates use the accumulator as holder of the rotated digit data.
// RULE5 - Register operands are selected by both bank flags plus opcode register code.
// RULE6 - Byte operand picked from eight by 3-bit code; pair picked from four.
// RULE7 - Codes 0..7 are X,A,C,B,E,D,L,H; pair codes 0..3 are AX,BC,DE,HL.
// RULE8 - Direct mode uses the full 16-bit immediate as address.
// RULE9 - Short direct reaches the fixed 256-byte window FE20H to FF1FH.
// RULE10 - FE20H-FEFFH of that window is high-speed RAM, FF00H-FF1FH is SFR.
// RULE11 - Short direct bit 8 is clear for 20H-FFH, set for 00H-1FH, upper bits ones.
// RULE12 - Word short direct operands must sit at even addresses.
// RULE13 - SFR mode reaches FF00H-FFCFH and FFE0H-FFFFH, never FFD0H-FFDFH.
// RULE14 - Word SFR operands must sit at even addresses.
// RULE15 - Register indirect uses ptr_pair_two or base_pair of the selected bank.
// RULE16 - Based adds zero-extended byte offset to base_pair, carry out dropped.
// RULE17 - Based indexed adds B or C of count_pair to base_pair, carry dropped.
// RULE18 - Stack accesses are addressed through stack_ptr.
// RULE19 - Stack addresses outside high-speed RAM are not supported.
// RULE20 - SFR address is all ones in upper byte and field in lower byte.
module operand_address_generator
   import oag_pkg::*;
#(
   parameter logic [15:0] HSRAM_LO = HSRAM_LO_DEF,
   parameter logic [15:0] HSRAM_HI = HSRAM_HI_DEF
)
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // Request from the decoder
   input  wire logic        REQ_VALID,
   input  wire logic [3:0]  REQ_MODE,
   input  wire logic [2:0]  REQ_CODE,
   input  wire logic [15:0] REQ_IMM,
   input  wire logic        REQ_WIDE,
   // Processor state
   input  wire logic        BANK_SELECT_BIT0,
   input  wire logic        BANK_SELECT_BIT1,
   input  wire logic [15:0] STACK_PTR,
   input  wire logic        CARRY_IN,
   input  wire logic        HALF_CARRY_IN,
   input  wire logic [7:0]  MEM_RDATA,
   // Register load from the CPU
   input  wire logic        REG_WE,
   input  wire logic [2:0]  REG_CODE,
   input  wire logic [7:0]  REG_WDATA,
   // Results
   output logic             ADDR_VALID,
   output logic [15:0]      EFF_ADDR,
   output logic             ADDR_ERR,
   output logic             OPND_VALID,
   output logic [15:0]      OPND_DATA,
   output logic             MEM_WE,
   output logic [7:0]       MEM_WDATA,
   output logic             CARRY_OUT,
   output logic             DONE,
   output logic             BUSY
);
   if (HSRAM_LO > HSRAM_HI) begin : g_chk
      $error("High-speed RAM bounds reversed");
   end

   rf_if rf ();

   gp_reg_file u_rf (
      .clk  (CLK),
      .srst (SRST),
      .port (rf.file)
   );

   function automatic logic [15:0] pair_of(input logic [7:0][7:0] b, input logic [1:0] p);
      return {b[{p, 1'b1}], b[{p, 1'b0}]};
   endfunction

   function automatic logic [15:0] saddr_ea(input logic [7:0] f);
      return {SADDR_HI7, (f < SADDR_SPLIT), f};
   endfunction

   state_e      state_r,      state_nxt;
   logic        addr_valid_r, addr_valid_nxt;
   logic [15:0] eff_addr_r,   eff_addr_nxt;
   logic        addr_err_r,   addr_err_nxt;
   logic        opnd_valid_r, opnd_valid_nxt;
   logic [15:0] opnd_data_r,  opnd_data_nxt;
   logic        mem_we_r,     mem_we_nxt;
   logic [7:0]  mem_wdata_r,  mem_wdata_nxt;
   logic        carry_r,      carry_nxt;
   logic        done_r,       done_nxt;
   logic        busy_r,       busy_nxt;
   logic [15:0] quo_r,        quo_nxt;
   logic [7:0]  rem_r,        rem_nxt;
   logic [7:0]  dvs_r,        dvs_nxt;
   logic [3:0]  cnt_r,        cnt_nxt;

   mode_e       mode;
   logic        take;
   logic [7:0]  a_reg;
   logic [7:0]  x_reg;
   logic [15:0] hl;
   logic [15:0] de;
   logic [15:0] prod;
   logic [7:0]  imm_lo;
   logic [3:0]  a_low;
   logic [3:0]  m_low;

   assign mode   = mode_e'(REQ_MODE);
   assign take   = REQ_VALID && (state_r == ST_IDLE);
   assign a_reg  = rf.bytes[CODE_A];
   assign x_reg  = rf.bytes[CODE_X];
   assign hl     = pair_of(rf.bytes, PAIR_HL);
   assign de     = pair_of(rf.bytes, PAIR_DE);
   assign prod   = 16'(a_reg) * 16'(x_reg);
   assign imm_lo = REQ_IMM[7:0];
   assign a_low  = a_reg[3:0];
   assign m_low  = MEM_RDATA[3:0];
   assign rf.bank = {BANK_SELECT_BIT1, BANK_SELECT_BIT0}; // RULE5

   always_comb begin
      logic [8:0] t;
      logic       ge;
      logic       lo_fix;
      logic       hi_fix;
      t              = {rem_r, quo_r[15]};
      ge             = 1'b0;
      lo_fix         = 1'b0;
      hi_fix         = 1'b0;
      state_nxt      = state_r;
      addr_valid_nxt = 1'b0;
      eff_addr_nxt   = eff_addr_r;
      addr_err_nxt   = 1'b0;
      opnd_valid_nxt = 1'b0;
      opnd_data_nxt  = opnd_data_r;
      mem_we_nxt     = 1'b0;
      mem_wdata_nxt  = mem_wdata_r;
      carry_nxt      = carry_r;
      done_nxt       = 1'b0;
      quo_nxt        = quo_r;
      rem_nxt        = rem_r;
      dvs_nxt        = dvs_r;
      cnt_nxt        = cnt_r;
      // CPU loads share the byte port; block results override
      rf.we_b        = REG_WE;
      rf.widx        = REG_CODE;
      rf.wbyte       = REG_WDATA;
      rf.we_w        = 1'b0;
      rf.wpidx       = PAIR_AX;
      rf.wword       = RST_WORD;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               case (mode)
                  M_REG8: begin
                     opnd_valid_nxt = 1'b1;
                     opnd_data_nxt  = {8'h00, rf.bytes[REQ_CODE]}; // RULE6
                  end
                  M_REG16: begin
                     opnd_valid_nxt = 1'b1;
                     opnd_data_nxt  = pair_of(rf.bytes, REQ_CODE[1:0]); // RULE7
                  end
                  M_DIRECT: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = REQ_IMM; // RULE8
                  end
                  M_SADDR: begin
                     // Low fields fold onto FF00H, so RAM and SFR halves share one byte
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = saddr_ea(imm_lo); // RULE9 RULE10 RULE11
                     addr_err_nxt   = REQ_WIDE && imm_lo[0]; // RULE12
                  end
                  M_SFR: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = {HIGH_PAGE, imm_lo}; // RULE20
                     addr_err_nxt   = (imm_lo >= SFR_GAP_LO && imm_lo <= SFR_GAP_HI) // RULE13
                                      || (REQ_WIDE && imm_lo[0]); // RULE14
                  end
                  M_IND: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = REQ_CODE[0] ? hl : de; // RULE15
                  end
                  M_BASED: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = hl + {8'h00, imm_lo}; // RULE16
                  end
                  M_BASED_IDX: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = hl + {8'h00, REQ_CODE[0] ? rf.bytes[CODE_B]
                                                             : rf.bytes[CODE_C]}; // RULE17
                  end
                  M_STACK: begin
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = STACK_PTR; // RULE18
                     addr_err_nxt   = (STACK_PTR < HSRAM_LO) || (STACK_PTR > HSRAM_HI); // RULE19
                  end
                  M_UNSIGNED_MULTIPLY_OP: begin
                     rf.we_w        = 1'b1;
                     rf.wpidx       = PAIR_AX;
                     rf.wword       = prod; // RULE1
                     opnd_valid_nxt = 1'b1;
                     opnd_data_nxt  = prod;
                     done_nxt       = 1'b1;
                  end
                  M_UNSIGNED_DIVIDE_WORD_OP: begin
                     // Divisor latched so a bank switch mid-divide cannot change it; results go to the bank selected at the end
                     state_nxt = ST_DIV;
                     quo_nxt   = pair_of(rf.bytes, PAIR_AX); // RULE2
                     rem_nxt   = RST_BYTE;
                     dvs_nxt   = rf.bytes[CODE_C];
                     cnt_nxt   = 4'h0;
                  end
                  M_ADJ_ADD, M_ADJ_SUB: begin
                     if (mode == M_ADJ_ADD) begin
                        lo_fix        = HALF_CARRY_IN || (a_low > BCD_NINE);
                        hi_fix        = CARRY_IN || (a_reg > BCD_MAX);
                        opnd_data_nxt = {8'h00, 8'(a_reg + (lo_fix ? BCD_LO_FIX : 8'h00)
                                                         + (hi_fix ? BCD_HI_FIX : 8'h00))};
                     end else begin
                        lo_fix        = HALF_CARRY_IN;
                        hi_fix        = CARRY_IN;
                        opnd_data_nxt = {8'h00, 8'(a_reg - (lo_fix ? BCD_LO_FIX : 8'h00)
                                                         - (hi_fix ? BCD_HI_FIX : 8'h00))};
                     end
                     rf.we_b        = 1'b1;
                     rf.widx        = CODE_A;
                     rf.wbyte       = opnd_data_nxt[7:0]; // RULE3
                     carry_nxt      = hi_fix;
                     opnd_valid_nxt = 1'b1;
                     done_nxt       = 1'b1;
                  end
                  M_DIGIT_ROTATE_RIGHT_OP, M_DIGIT_ROTATE_LEFT_OP: begin
                     // Memory byte at base_pair must arrive with the request
                     addr_valid_nxt = 1'b1;
                     eff_addr_nxt   = hl;
                     mem_we_nxt     = 1'b1;
                     rf.we_b        = 1'b1;
                     rf.widx        = CODE_A;
                     if (mode == M_DIGIT_ROTATE_LEFT_OP) begin
                        mem_wdata_nxt = {m_low, a_low};
                        rf.wbyte      = {a_reg[7:4], MEM_RDATA[7:4]}; // RULE4
                     end else begin
                        mem_wdata_nxt = {a_low, MEM_RDATA[7:4]};
                        rf.wbyte      = {a_reg[7:4], m_low}; // RULE4
                     end
                     opnd_valid_nxt = 1'b1;
                     opnd_data_nxt  = {8'h00, rf.wbyte};
                     done_nxt       = 1'b1;
                  end
                  default: begin
                     opnd_data_nxt = opnd_data_r;
                  end
               endcase
            end
         end
         ST_DIV: begin
            // One quotient bit per clock keeps the divider small
            ge      = t >= {1'b0, dvs_r};
            rem_nxt = ge ? 8'(t - {1'b0, dvs_r}) : t[7:0];
            quo_nxt = {quo_r[14:0], ge};
            cnt_nxt = 4'(cnt_r + 4'h1);
            if (cnt_r == DIV_LAST) begin
               state_nxt      = ST_IDLE;
               rf.we_w        = 1'b1;
               rf.wpidx       = PAIR_AX;
               rf.wword       = quo_nxt; // RULE2
               rf.we_b        = 1'b1;
               rf.widx        = CODE_C;
               rf.wbyte       = rem_nxt;
               opnd_valid_nxt = 1'b1;
               opnd_data_nxt  = quo_nxt;
               done_nxt       = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_r      <= ST_IDLE;
         addr_valid_r <= 1'b0;
         eff_addr_r   <= RST_WORD;
         addr_err_r   <= 1'b0;
         opnd_valid_r <= 1'b0;
         opnd_data_r  <= RST_WORD;
         mem_we_r     <= 1'b0;
         mem_wdata_r  <= RST_BYTE;
         carry_r      <= 1'b0;
         done_r       <= 1'b0;
         busy_r       <= 1'b0;
         quo_r        <= RST_WORD;
         rem_r        <= RST_BYTE;
         dvs_r        <= RST_BYTE;
         cnt_r        <= 4'h0;
      end else begin
         state_r      <= state_nxt;
         addr_valid_r <= addr_valid_nxt;
         eff_addr_r   <= eff_addr_nxt;
         addr_err_r   <= addr_err_nxt;
         opnd_valid_r <= opnd_valid_nxt;
         opnd_data_r  <= opnd_data_nxt;
         mem_we_r     <= mem_we_nxt;
         mem_wdata_r  <= mem_wdata_nxt;
         carry_r      <= carry_nxt;
         done_r       <= done_nxt;
         busy_r       <= busy_nxt;
         quo_r        <= quo_nxt;
         rem_r        <= rem_nxt;
         dvs_r        <= dvs_nxt;
         cnt_r        <= cnt_nxt;
      end
   end

   assign ADDR_VALID = addr_valid_r;
   assign EFF_ADDR   = eff_addr_r;
   assign ADDR_ERR   = addr_err_r;
   assign OPND_VALID = opnd_valid_r;
   assign OPND_DATA  = opnd_data_r;
   assign MEM_WE     = mem_we_r;
   assign MEM_WDATA  = mem_wdata_r;
   assign CARRY_OUT  = carry_r;
   assign DONE       = done_r;
   assign BUSY       = busy_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   property p_unsigned_multiply_op; // RULE1
      take && mode == M_UNSIGNED_MULTIPLY_OP |=> DONE && OPND_DATA == 16'($past(a_reg)) * 16'($past(x_reg));
   endproperty
   a_unsigned_multiply_op: assert property (p_unsigned_multiply_op) else $error("product wrong"); // RULE1

   property p_unsigned_divide_word_op; // RULE2
      take && mode == M_UNSIGNED_DIVIDE_WORD_OP |=> BUSY [*8] ##1 BUSY [*8] ##1 DONE && !BUSY;
   endproperty
   a_unsigned_divide_word_op: assert property (p_unsigned_divide_word_op) else $error("divide length wrong"); // RULE2

   property p_adj; // RULE3
      take && mode == M_ADJ_ADD && !CARRY_IN && !HALF_CARRY_IN && a_reg <= BCD_MAX
         && a_low <= BCD_NINE |=> OPND_DATA[7:0] == $past(a_reg) && !CARRY_OUT;
   endproperty
   a_adj: assert property (p_adj) else $error("valid BCD changed"); // RULE3

   property p_rol; // RULE4
      take && mode == M_DIGIT_ROTATE_LEFT_OP |=> MEM_WE && MEM_WDATA == {$past(m_low), $past(a_low)}
         && EFF_ADDR == $past(hl);
   endproperty
   a_rol: assert property (p_rol) else $error("digit rotate wrong"); // RULE4

   property p_reg8; // RULE7
      take && mode == M_REG8 && REQ_CODE == CODE_A |=> OPND_VALID
         && OPND_DATA == {8'h00, $past(a_reg)};
   endproperty
   a_reg8: assert property (p_reg8) else $error("register code map wrong"); // RULE7

   property p_direct; // RULE8
      take && mode == M_DIRECT |=> ADDR_VALID && EFF_ADDR == $past(REQ_IMM);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong"); // RULE8

   property p_saddr; // RULE11
      take && mode == M_SADDR |=> EFF_ADDR[15:9] == SADDR_HI7
         && EFF_ADDR[8] == ($past(imm_lo) < SADDR_SPLIT) && EFF_ADDR[7:0] == $past(imm_lo);
   endproperty
   a_saddr: assert property (p_saddr) else $error("short direct address wrong"); // RULE11

   property p_sfr_gap; // RULE13
      take && mode == M_SFR && imm_lo >= SFR_GAP_LO && imm_lo <= SFR_GAP_HI |=> ADDR_ERR;
   endproperty
   a_sfr_gap: assert property (p_sfr_gap) else $error("gap not refused"); // RULE13

   property p_based; // RULE16
      take && mode == M_BASED |=> EFF_ADDR == 16'($past(hl) + 16'($past(imm_lo)));
   endproperty
   a_based: assert property (p_based) else $error("based address wrong"); // RULE16

   property p_stack; // RULE19
      take && mode == M_STACK && STACK_PTR > HSRAM_HI |=> ADDR_VALID && ADDR_ERR;
   endproperty
   a_stack: assert property (p_stack) else $error("stack outside RAM not flagged"); // RULE19
endmodule

/* pkg/oag_pkg.sv */
package oag_pkg;
   // Effective address forming
   localparam logic [7:0]  HIGH_PAGE    = 8'hFF;
   localparam logic [6:0]  SADDR_HI7    = 7'h7F;
   localparam logic [7:0]  SADDR_SPLIT  = 8'h20;
   localparam logic [7:0]  SFR_GAP_LO   = 8'hD0;
   localparam logic [7:0]  SFR_GAP_HI   = 8'hDF;
   localparam logic [15:0] HSRAM_LO_DEF = 16'hFB00;
   localparam logic [15:0] HSRAM_HI_DEF = 16'hFEFF;
   // Absolute register and pair codes
   localparam logic [2:0]  CODE_X       = 3'h0;
   localparam logic [2:0]  CODE_A       = 3'h1;
   localparam logic [2:0]  CODE_C       = 3'h2;
   localparam logic [2:0]  CODE_B       = 3'h3;
   localparam logic [2:0]  CODE_E       = 3'h4;
   localparam logic [2:0]  CODE_D       = 3'h5;
   localparam logic [2:0]  CODE_L       = 3'h6;
   localparam logic [2:0]  CODE_H       = 3'h7;
   localparam logic [1:0]  PAIR_AX      = 2'h0;
   localparam logic [1:0]  PAIR_BC      = 2'h1;
   localparam logic [1:0]  PAIR_DE      = 2'h2;
   localparam logic [1:0]  PAIR_HL      = 2'h3;
   // Arithmetic constants and reset values
   localparam logic [3:0]  DIV_LAST     = 4'hF;
   localparam logic [3:0]  BCD_NINE     = 4'h9;
   localparam logic [7:0]  BCD_MAX      = 8'h99;
   localparam logic [7:0]  BCD_LO_FIX   = 8'h06;
   localparam logic [7:0]  BCD_HI_FIX   = 8'h60;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;

   typedef enum logic [3:0] {
      M_NONE      = 4'h0,
      M_REG8      = 4'h1,
      M_REG16     = 4'h2,
      M_DIRECT    = 4'h3,
      M_SADDR     = 4'h4,
      M_SFR       = 4'h5,
      M_IND       = 4'h6,
      M_BASED     = 4'h7,
      M_BASED_IDX = 4'h8,
      M_STACK     = 4'h9,
      M_UNSIGNED_MULTIPLY_OP      = 4'hA,
      M_UNSIGNED_DIVIDE_WORD_OP     = 4'hB,
      M_ADJ_ADD   = 4'hC,
      M_ADJ_SUB   = 4'hD,
      M_DIGIT_ROTATE_RIGHT_OP      = 4'hE,
      M_DIGIT_ROTATE_LEFT_OP      = 4'hF
   } mode_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_DIV  = 1'b1
   } state_e;
endpackage

/* pkg/rf_if.sv */
`timescale 1ns/1ns
interface rf_if;
   logic [1:0]      bank;
   logic [7:0][7:0] bytes;
   logic            we_b;
   logic [2:0]      widx;
   logic [7:0]      wbyte;
   logic            we_w;
   logic [1:0]      wpidx;
   logic [15:0]     wword;
   modport core (output bank, we_b, widx, wbyte, we_w, wpidx, wword, input bytes);
   modport file (input bank, we_b, widx, wbyte, we_w, wpidx, wword, output bytes);
endinterface

/* verilog/gp_reg_file.sv */
`timescale 1ns/1ns
module gp_reg_file
   import oag_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Core side
   rf_if.file       port
);
   logic [7:0] mem_r   [4][8];
   logic [7:0] mem_nxt [4][8];

   // Word write after byte write, so a pair write wins on overlap
   always_comb begin
      mem_nxt = mem_r;
      if (port.we_b) begin
         mem_nxt[port.bank][port.widx] = port.wbyte;
      end
      if (port.we_w) begin
         mem_nxt[port.bank][{port.wpidx, 1'b1}] = port.wword[15:8];
         mem_nxt[port.bank][{port.wpidx, 1'b0}] = port.wword[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int b = 0; b < 4; b++) begin
            for (int i = 0; i < 8; i++) begin
               mem_r[b][i] <= RST_BYTE;
            end
         end
      end else begin
         mem_r <= mem_nxt;
      end
   end

   // Only the selected bank is visible
   for (genvar i = 0; i < 8; i++) begin : g_view
      assign port.bytes[i] = mem_r[port.bank][i];
   end
endmodule

/* verification/operand_address_generator_test.sv */
`timescale 1ns/1ns
module operand_address_generator_test;
   import oag_pkg::*;
   // Stimulus and observed signals
   logic        clk, srst, req_valid, req_wide, bs0, bs1, carry_in, half_carry_in, reg_we;
   logic [3:0]  req_mode;
   logic [2:0]  req_code, reg_code;
   logic [15:0] req_imm, stack_ptr, eff_addr, opnd_data;
   logic [7:0]  mem_rdata, reg_wdata, mem_wdata;
   logic        addr_valid, addr_err, opnd_valid, mem_we, carry_out, done, busy;
   int          num_errors, check_count, n;

   operand_address_generator uut (
      .CLK(clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_MODE(req_mode),
      .REQ_CODE(req_code), .REQ_IMM(req_imm), .REQ_WIDE(req_wide),
      .BANK_SELECT_BIT0(bs0), .BANK_SELECT_BIT1(bs1), .STACK_PTR(stack_ptr),
      .CARRY_IN(carry_in), .HALF_CARRY_IN(half_carry_in), .MEM_RDATA(mem_rdata),
      .REG_WE(reg_we), .REG_CODE(reg_code), .REG_WDATA(reg_wdata),
      .ADDR_VALID(addr_valid), .EFF_ADDR(eff_addr), .ADDR_ERR(addr_err),
      .OPND_VALID(opnd_valid), .OPND_DATA(opnd_data), .MEM_WE(mem_we),
      .MEM_WDATA(mem_wdata), .CARRY_OUT(carry_out), .DONE(done), .BUSY(busy));

   initial clk = 1'h0;
   always #25 clk = ~clk;

   task automatic final_report;
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One request cycle; outputs are settled at the following falling edge
   task automatic req(input logic [3:0] m, input logic [2:0] c, input logic [15:0] imm,
                      input logic w);
      @(negedge clk);
      req_valid = 1'h1;
      req_mode = m;
      req_code = c;
      req_imm = imm;
      req_wide = w;
      @(negedge clk);
      req_valid = 1'h0;
   endtask

   task automatic wreg(input logic [1:0] b, input logic [2:0] c, input logic [7:0] d);
      @(negedge clk);
      {bs1, bs0} = b;
      reg_we = 1'h1;
      reg_code = c;
      reg_wdata = d;
      @(negedge clk);
      reg_we = 1'h0;
   endtask

   task automatic rd(input logic [3:0] m, input logic [2:0] c, input logic [15:0] exp);
      req(m, c, 16'h0000, 1'h0);
      chk("opnd_valid", 16'h0001, {15'h0000, opnd_valid});
      chk("opnd_data", exp, opnd_data);
   endtask

   task automatic ea(input logic [3:0] m, input logic [2:0] c, input logic [15:0] imm,
                     input logic w, input logic [15:0] exp, input logic err);
      req(m, c, imm, w);
      chk("addr_valid", 16'h0001, {15'h0000, addr_valid});
      chk("addr_err", {15'h0000, err}, {15'h0000, addr_err});
      if (!err) begin
         chk("eff_addr", exp, eff_addr);
      end
   endtask

   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         wreg(2'h1, 3'(i), 8'(8'h10 + i));
      end
      for (int i = 0; i < 8; i++) begin
         rd(M_REG8, 3'(i), 16'(8'h10 + i));
      end
      for (int p = 0; p < 4; p++) begin
         rd(M_REG16, 3'(p), {8'(8'h11 + 2 * p), 8'(8'h10 + 2 * p)});
      end
      // Another bank must not see bank 1 contents
      {bs1, bs0} = 2'h2;
      rd(M_REG8, 3'h3, 16'h0000);
   endtask

   task automatic t_saddr_sfr;
      ea(M_DIRECT, 3'h0, 16'hFE00, 1'h0, 16'hFE00, 1'h0);
      ea(M_DIRECT, 3'h0, 16'h0001, 1'h0, 16'h0001, 1'h0);
      ea(M_SADDR, 3'h0, 16'h0020, 1'h0, 16'hFE20, 1'h0);
      ea(M_SADDR, 3'h0, 16'h00FF, 1'h0, 16'hFEFF, 1'h0);
      ea(M_SADDR, 3'h0, 16'h0000, 1'h0, 16'hFF00, 1'h0);
      ea(M_SADDR, 3'h0, 16'h001F, 1'h0, 16'hFF1F, 1'h0);
      ea(M_SADDR, 3'h0, 16'h0030, 1'h1, 16'hFE30, 1'h0);
      ea(M_SADDR, 3'h0, 16'h0021, 1'h1, 16'h0000, 1'h1);
      ea(M_SFR, 3'h0, 16'h0020, 1'h0, 16'hFF20, 1'h0);
      ea(M_SFR, 3'h0, 16'h00CF, 1'h0, 16'hFFCF, 1'h0);
      ea(M_SFR, 3'h0, 16'h00E0, 1'h0, 16'hFFE0, 1'h0);
      ea(M_SFR, 3'h0, 16'h00D0, 1'h0, 16'h0000, 1'h1);
      ea(M_SFR, 3'h0, 16'h00DF, 1'h0, 16'h0000, 1'h1);
      ea(M_SFR, 3'h0, 16'h0022, 1'h1, 16'hFF22, 1'h0);
      ea(M_SFR, 3'h0, 16'h0023, 1'h1, 16'h0000, 1'h1);
      // Mode none must leave addr_valid, opnd_valid and done low
      req(M_NONE, 3'h0, 16'h0000, 1'h0);
      chk("none_strobes", 16'h0000, {13'h0000, addr_valid, opnd_valid, done});
   endtask

   // Bank 1 holds DE=1514, HL=1716, B=13, C=12 from t_regs
   task automatic t_ptr;
      {bs1, bs0} = 2'h1;
      ea(M_IND, 3'h0, 16'h0000, 1'h0, 16'h1514, 1'h0);
      ea(M_IND, 3'h1, 16'h0000, 1'h0, 16'h1716, 1'h0);
      ea(M_BASED, 3'h0, 16'h00FF, 1'h0, 16'h1815, 1'h0);
      ea(M_BASED_IDX, 3'h0, 16'h0000, 1'h0, 16'h1728, 1'h0);
      ea(M_BASED_IDX, 3'h1, 16'h0000, 1'h0, 16'h1729, 1'h0);
      wreg(2'h3, CODE_H, 8'hFF);
      wreg(2'h3, CODE_L, 8'hF0);
      wreg(2'h3, CODE_C, 8'h20);
      wreg(2'h3, CODE_B, 8'h30);
      ea(M_BASED, 3'h0, 16'h0020, 1'h0, 16'h0010, 1'h0);
      ea(M_BASED_IDX, 3'h0, 16'h0000, 1'h0, 16'h0010, 1'h0);
      ea(M_BASED_IDX, 3'h1, 16'h0000, 1'h0, 16'h0020, 1'h0);
   endtask

   task automatic t_stack;
      logic [15:0] sp [5] = '{16'hFE00, 16'hFB00, 16'hFEFF, 16'hFAFF, 16'hFF00};
      for (int i = 0; i < 5; i++) begin
         stack_ptr = sp[i];
         ea(M_STACK, 3'h0, 16'h0000, 1'h0, sp[i], 1'(i > 2));
      end
   endtask

   task automatic t_arith;
      wreg(2'h0, CODE_A, 8'h12);
      wreg(2'h0, CODE_X, 8'h34);
      req(M_UNSIGNED_MULTIPLY_OP, 3'h0, 16'h0000, 1'h0);
      chk("done", 16'h0001, {15'h0000, done});
      chk("product", 16'h03A8, opnd_data);
      rd(M_REG16, PAIR_AX, 16'h03A8);
      wreg(2'h0, CODE_A, 8'h12);
      wreg(2'h0, CODE_X, 8'h34);
      wreg(2'h0, CODE_C, 8'h10);
      req(M_UNSIGNED_DIVIDE_WORD_OP, 3'h0, 16'h0000, 1'h0);
      chk("busy", 16'h0001, {15'h0000, busy});
      // A request while busy must be dropped
      req(M_DIRECT, 3'h0, 16'h1234, 1'h0);
      chk("addr_valid", 16'h0000, {15'h0000, addr_valid});
      n = 1;
      while (done !== 1'h1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20) begin
         num_errors++;
         $display("ERROR divide_done expected 1 seen %b", done);
         final_report;
      end
      chk("div_cycles", 16'd15, 16'(n));
      chk("quotient", 16'h0123, opnd_data);
      rd(M_REG16, PAIR_AX, 16'h0123);
      rd(M_REG8, CODE_C, 16'h0004);
   endtask

   task automatic adj(input logic [3:0] m, input logic [7:0] a, input logic cy,
                      input logic hc, input logic [7:0] exp, input logic ecy);
      wreg(2'h0, CODE_A, a);
      carry_in = cy;
      half_carry_in = hc;
      req(m, 3'h0, 16'h0000, 1'h0);
      chk("done", 16'h0001, {15'h0000, done});
      chk("carry_out", {15'h0000, ecy}, {15'h0000, carry_out});
      rd(M_REG8, CODE_A, {8'h00, exp});
   endtask

   task automatic t_adj_rot;
      adj(M_ADJ_ADD, 8'h1C, 1'h0, 1'h0, 8'h22, 1'h0);
      adj(M_ADJ_ADD, 8'h45, 1'h0, 1'h0, 8'h45, 1'h0);
      adj(M_ADJ_ADD, 8'hA0, 1'h0, 1'h0, 8'h00, 1'h1);
      adj(M_ADJ_SUB, 8'h6F, 1'h1, 1'h1, 8'h09, 1'h1);
      wreg(2'h0, CODE_H, 8'hFE);
      wreg(2'h0, CODE_L, 8'h80);
      for (int i = 0; i < 2; i++) begin
         wreg(2'h0, CODE_A, 8'h5A);
         mem_rdata = 8'hC3;
         req(i ? M_DIGIT_ROTATE_LEFT_OP : M_DIGIT_ROTATE_RIGHT_OP, 3'h0, 16'h0000, 1'h0);
         chk("mem_we", 16'h0001, {15'h0000, mem_we});
         chk("rot_addr", 16'hFE80, eff_addr);
         chk("rot_wdata", i ? 16'h003A : 16'h00AC, {8'h00, mem_wdata});
         // Upper accumulator digit never takes part in the rotation
         rd(M_REG8, CODE_A, i ? 16'h005C : 16'h0053);
         chk("acc_hi", 16'h0005, {12'h000, opnd_data[7:4]});
      end
   endtask

   initial begin
      {srst, req_valid, req_wide, bs0, bs1, carry_in, half_carry_in, reg_we} = 8'hFF;
      {req_valid, req_wide, bs0, bs1, carry_in, half_carry_in, reg_we} = 7'h00;
      req_mode = 4'h0;
      req_code = 3'h0;
      reg_code = 3'h0;
      req_imm = 16'h0000;
      stack_ptr = 16'hFE00;
      mem_rdata = 8'h00;
      reg_wdata = 8'h00;
      repeat (5) @(negedge clk);
      srst = 1'h0;
      chk("reset_busy", 16'h0000, {15'h0000, busy});
      chk("reset_addr", 16'h0000, eff_addr);
      t_regs;
      t_saddr_sfr;
      t_ptr;
      t_stack;
      t_arith;
      t_adj_rot;
      final_report;
   end
endmodule
